// ### ltx_pkg.sv
// Constants and types shared by both ends of the transmit path
package ltx_pkg;
   localparam logic [1:0] LTX_FMT_SNRZ = 2'h0;
   localparam logic [1:0] LTX_FMT_DNRZ = 2'h1;
   localparam logic [1:0] LTX_FMT_DRZ  = 2'h2;
   localparam int LTX_SYS_NS   = 50;
   localparam int LTX_LINE_NS  = 648;
   localparam int LTX_UI_CYC   = LTX_LINE_NS / LTX_SYS_NS;
   localparam int LTX_LOSS_UI  = 64;
   localparam int LTX_LOSS_CYC = (LTX_LOSS_UI * LTX_LINE_NS + LTX_SYS_NS - 1) / LTX_SYS_NS;
   localparam int LTX_NSAMP    = 20;
   localparam int LTX_WAC_RW   = 5;
   localparam int LTX_WAC_DONE = 6;
   localparam int LTX_TMPL_USR = 3;
   localparam int LTX_SGN_BIT  = 6;
   localparam logic [3:0] LTX_TMPL_E1C = 4'h0;
   localparam logic [3:0] LTX_TMPL_E1T = 4'h1;
   localparam logic [5:0] LTX_SCALE_RST = 6'h36;
   localparam logic [5:0] LTX_SCALE_E1  = 6'h21;
   localparam int LTX_PCT_T1   = 2;
   localparam int LTX_PCT_E1   = 3;
   localparam int LTX_PCT_BASE = 100;
   localparam int LTX_AMP_MAX  = 63;
   localparam int LTX_ST_NRZ_MAX = 4;
   localparam logic [1:0] LTX_SYM_POS  = 2'h2;
   localparam logic [1:0] LTX_SYM_NEG  = 2'h1;
   localparam logic [1:0] LTX_SYM_ZERO = 2'h0;
   typedef logic [6:0] ltx_samp_t;
   localparam ltx_samp_t LTX_ROM_T1 [LTX_NSAMP] = '{7'h17, 7'h27, 7'h27, 7'h26, 7'h25,
      7'h25, 7'h25, 7'h24, 7'h23, 7'h4A, 7'h4A, 7'h49, 7'h47, 7'h45, 7'h44, 7'h43, 7'h42,
      7'h41, 7'h00, 7'h00};
   // Only the fourth and fifth samples of the E1 pulses are non-zero
   localparam ltx_samp_t LTX_ROM_E1C [LTX_NSAMP] = '{3: 7'h0C, 4: 7'h30, default: 7'h00};
   localparam ltx_samp_t LTX_ROM_E1T [LTX_NSAMP] = '{3: 7'h0F, 4: 7'h3C, default: 7'h00};
endpackage

// ### ltx_link_if.sv
// Pins between the system-side framer and the transmit path
`timescale 1ns/1ns
interface ltx_link_if;
   logic line_a;
   logic line_c;
   logic b_host;
   logic b_host_oe;
   logic b_dev;
   logic b_dev_oe;
   logic line_b;
   // Shared pin level resolved from both enables
   assign line_b = b_dev_oe ? b_dev : (b_host_oe & b_host);
   modport dev  (input line_a, line_b, line_c, output b_dev, b_dev_oe);
   modport host (output line_a, line_c, b_host, b_host_oe, input line_b);
endinterface

// ### ltx_fifo.sv
// Parameterised FIFO with valid and ready on both sides
`timescale 1ns/1ns
module ltx_fifo #(
   parameter int WIDTH = 2,
   parameter int DEPTH = 16
) (
   // Clock and reset
   input  wire logic             clk_sys,
   input  wire logic             rst_b,
   // Fill side
   input  wire logic             in_valid,
   output logic                  in_ready,
   input  wire logic [WIDTH-1:0] in_data,
   // Drain side
   output logic                  out_valid,
   input  wire logic             out_ready,
   output logic [WIDTH-1:0]      out_data
);
   localparam int AW = $clog2(DEPTH);
   logic [WIDTH-1:0] mem_r [DEPTH];
   logic [AW:0]      wp_r;
   logic [AW:0]      rp_r;

   if (DEPTH < 2 || (2 ** AW) != DEPTH) begin : g_chk
      $error("FIFO depth must be a power of two");
   end

   // Full when pointers differ only in the wrap bit
   assign in_ready  = !((wp_r[AW] != rp_r[AW]) && (wp_r[AW-1:0] == rp_r[AW-1:0]));
   assign out_valid = (wp_r != rp_r);
   assign out_data  = mem_r[rp_r[AW-1:0]];

   // Storage
   always_ff @(posedge clk_sys) begin
      if (in_valid && in_ready) begin
         mem_r[wp_r[AW-1:0]] <= in_data;
      end
   end

   // Pointers
   always_ff @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
         wp_r <= '0;
         rp_r <= '0;
      end else begin
         if (in_valid && in_ready) begin
            wp_r <= wp_r + 1'b1;
         end
         if (out_valid && out_ready) begin
            rp_r <= rp_r + 1'b1;
         end
      end
   end
endmodule

// ### ltx_framer.sv
// System-side framer end: buffers rail words and drives the link pins
`timescale 1ns/1ns
module ltx_framer import ltx_pkg::*; #(
   parameter int UI_CYCLES = LTX_UI_CYC,
   parameter int DEPTH     = 16
) (
   // Clock and reset
   input  wire logic       clk_sys,
   input  wire logic       rst_b,
   // Link
   ltx_link_if.host        link,
   // Configuration
   input  wire logic [1:0] fmt,
   input  wire logic       edge_sel,
   input  wire logic       polarity_sel,
   // Word stream, bit 1 positive or single data, bit 0 negative
   input  wire logic       in_valid,
   output logic            in_ready,
   input  wire logic [1:0] in_data,
   // Status seen on the shared pin
   output logic            status_seen
);
   localparam int HALF = UI_CYCLES / 2;
   localparam int CW   = $clog2(UI_CYCLES);
   logic [CW-1:0] cnt_r;
   logic          clk_r;
   logic [1:0]    dat_r;
   logic          s1_r;
   logic          s2_r;
   logic          out_valid;
   logic [1:0]    out_data;
   logic          tick0;
   logic          tickh;
   logic          launch;

   if (UI_CYCLES < 4) begin : g_chk
      $error("UI_CYCLES too small");
   end

   ltx_fifo #(.WIDTH(2), .DEPTH(DEPTH)) u_fifo (
      .clk_sys   (clk_sys),
      .rst_b     (rst_b),
      .in_valid  (in_valid),
      .in_ready  (in_ready),
      .in_data   (in_data),
      .out_valid (out_valid),
      .out_ready (launch),
      .out_data  (out_data)
   );

   // Launch on the edge opposite the sampling edge; RZ launches at bit start
   assign tick0  = (cnt_r == '0);
   assign tickh  = (cnt_r == CW'(HALF));
   assign launch = (fmt == LTX_FMT_DRZ || edge_sel) ? tick0 : tickh;

   // Line clock divider
   always_ff @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
         cnt_r <= '0;
         clk_r <= 1'b0;
      end else begin
         cnt_r <= (cnt_r == CW'(UI_CYCLES - 1)) ? '0 : cnt_r + 1'b1;
         if (tick0) begin
            clk_r <= 1'b1;
         end else if (tickh) begin
            clk_r <= 1'b0;
         end
      end
   end

   // Rail marks kept logical so reset leaves the pins idle in either polarity
   always_ff @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
         dat_r <= 2'h0;
      end else if (launch) begin
         dat_r <= out_valid ? out_data : 2'h0;
      end else if (tickh && fmt == LTX_FMT_DRZ) begin
         dat_r <= 2'h0;
      end
   end

   // Status pin synchroniser
   always_ff @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
         s1_r <= 1'b0;
         s2_r <= 1'b0;
      end else begin
         s1_r <= link.line_b;
         s2_r <= s1_r;
      end
   end

   // Pin mapping; negative rail moves to the clock pin in RZ
   assign link.line_a    = dat_r[1] ^ polarity_sel;
   assign link.line_c    = (fmt == LTX_FMT_DRZ) ? dat_r[0] ^ polarity_sel : clk_r;
   assign link.b_host    = dat_r[0] ^ polarity_sel;
   assign link.b_host_oe = (fmt == LTX_FMT_DNRZ);
   assign status_seen    = s2_r;
endmodule

// ### ltx_lineunit.sv
// Device end: transmit interface, clock loss, recovery, encoder and shaper
`timescale 1ns/1ns
// Operation
// [RQ1] Two-bit field selects one of three formats
// [RQ2] Single rail: sample data on active clock edge
// [RQ3] Single rail: status pin updated on active edge
// [RQ4] Dual NRZ: sample both rails, no re-encoding
// [RQ5] Dual RZ: recover clock, extra status choices
// [RQ6] RZ: negative rail on clock pin, polarity select
// [RQ7] Edge select; clock loss after 64 idle bits
// [RQ8] Clock loss flag on rise or any change
// [RQ9] Clock recovery only in dual RZ
// [RQ10] Encoder only in single rail NRZ
// [RQ11] AMI, B8ZS in T1, HDB3 in E1
// [RQ12] Codes 0010 to 0110 pick T1 templates
// [RQ13] E1 software picks template 0000 or 0001
// [RQ14] Scale resets to 110110, 2% per step
// [RQ15] E1 standard scale 100001, 3% per step
// [RQ16] Template top bit selects user waveform memory
// [RQ17] Twenty samples addressed by five-bit field
// [RQ18] Seven-bit signed-magnitude samples, plus/minus 63
// [RQ19] Write: load data, then control with done
// [RQ20] Read: control with read and done, read data
// [RQ21] Overlap overflow sets DAC flag and interrupt
// [RQ22] Done bit clears when access completes
// [RQ23] Clock loss clears when transitions resume
module ltx_lineunit import ltx_pkg::*; #(
   parameter int UI_CYCLES = LTX_UI_CYC
) (
   // Clock and reset
   input  wire logic       clk_sys,
   input  wire logic       rst_b,
   // Link
   ltx_link_if.dev         link,
   // Configuration
   input  wire logic [1:0] tx_format_select,
   input  wire logic       tx_data_polarity_sel,
   input  wire logic       tx_clock_edge_sel,
   input  wire logic       tx_line_code_sel,
   input  wire logic       e1_mode,
   input  wire logic [3:0] pulse_template_sel,
   input  wire logic [2:0] status_sel,
   input  wire logic [7:0] tx_indications,
   // Amplitude scale register
   input  wire logic       scale_we,
   input  wire logic [5:0] scale_wdata,
   output logic [5:0]      amplitude_scale,
   // Waveform memory access registers
   input  wire logic       wave_ctrl_we,
   input  wire logic [6:0] wave_ctrl_wdata,
   input  wire logic       wave_data_we,
   input  wire logic [6:0] wave_data_wdata,
   output logic [6:0]      wave_access_control_reg,
   output logic [6:0]      wave_sample_data_reg,
   // Events and interrupt
   input  wire logic       tx_clock_loss_edge_sel,
   input  wire logic       tx_clock_loss_irq_mask,
   input  wire logic       dac_overflow_irq_mask,
   input  wire logic [1:0] irq_clear,
   output logic            tx_clock_loss_status,
   output logic            tx_clock_loss_irq_flag,
   output logic            dac_overflow_irq_flag,
   output logic            irq_n,
   // Line side
   output logic [1:0]      tx_symbol,
   output logic            tx_symbol_valid,
   output logic [7:0]      tx_dac_level
);
   localparam int HALF = UI_CYCLES / 2;
   localparam int RW   = $clog2(2 * UI_CYCLES);
   localparam int LW   = $clog2(LTX_LOSS_CYC + 1);
   logic [2:0]      s1_r;
   logic [2:0]      s2_r;
   logic [2:0]      d_r;
   logic [LW-1:0]   loss_cnt_r;
   logic            loss_d_r;
   logic [RW-1:0]   rec_cnt_r;
   logic [7:0][1:0] sym_r;
   logic [7:0][1:0] enc_nxt;
   logic            pol_r;
   logic            pol_nxt;
   logic            odd_r;
   logic            odd_nxt;
   logic [1:0]      new_sym;
   ltx_samp_t       mem_r [LTX_NSAMP];
   logic [4:0]      cur_ph_r;
   logic [4:0]      prv_ph_r;
   logic            cur_neg_r;
   logic            prv_neg_r;
   logic            status_r;
   logic            is_rz;
   logic            rise;
   logic            fall;
   logic            samp_stb;
   logic            rz_mark;
   logic            rz_zero;
   logic            sym_stb;
   logic [1:0]      sym_val;
   logic [2:0]      pins;
   logic            acc_go;
   logic            acc_ok;
   logic [4:0]      acc_addr;
   int              sum_c;

   if (UI_CYCLES < 4) begin : g_chk
      $error("UI_CYCLES too small");
   end

   // Two-stage synchronisers for pins a, b, c
   always_ff @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
         s1_r <= 3'h0;
         s2_r <= 3'h0;
         d_r  <= 3'h0;
      end else begin
         s1_r <= {link.line_c, link.line_b, link.line_a};
         s2_r <= s1_r;
         d_r  <= s2_r;
      end
   end

   // Data inputs follow the polarity select; clock pin stays raw in NRZ
   assign is_rz    = (tx_format_select == LTX_FMT_DRZ);               // [RQ1]
   assign pins     = s2_r ^ {is_rz, 2'b11} & {3{tx_data_polarity_sel}}; // [RQ6]
   assign rise     = s2_r[2] & ~d_r[2];
   assign fall     = ~s2_r[2] & d_r[2];
   assign samp_stb = !is_rz && (tx_clock_edge_sel ? fall : rise);    // [RQ7]

   // Clock loss watch on the clock pin in NRZ formats
   always_ff @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
         loss_cnt_r           <= '0;
         tx_clock_loss_status <= 1'b0;
      end else if (is_rz || rise || fall) begin
         loss_cnt_r           <= '0;
         tx_clock_loss_status <= 1'b0;                                // [RQ23]
      end else if (loss_cnt_r == LW'(LTX_LOSS_CYC)) begin
         tx_clock_loss_status <= 1'b1;                                // [RQ7]
      end else begin
         loss_cnt_r <= loss_cnt_r + 1'b1;
      end
   end

   // Sticky event flags; a new event beats a clear in the same cycle
   always_ff @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
         loss_d_r               <= 1'b0;
         tx_clock_loss_irq_flag <= 1'b0;
         dac_overflow_irq_flag  <= 1'b0;
      end else begin
         loss_d_r <= tx_clock_loss_status;
         if (tx_clock_loss_edge_sel ? (tx_clock_loss_status != loss_d_r)
                                    : (tx_clock_loss_status && !loss_d_r)) begin
            tx_clock_loss_irq_flag <= 1'b1;                           // [RQ8]
         end else if (irq_clear[0]) begin
            tx_clock_loss_irq_flag <= 1'b0;
         end
         if (sum_c > LTX_AMP_MAX || sum_c < -LTX_AMP_MAX) begin
            dac_overflow_irq_flag <= 1'b1;                            // [RQ21]
         end else if (irq_clear[1]) begin
            dac_overflow_irq_flag <= 1'b0;
         end
      end
   end

   // Interrupt output, a mask bit of one blocks its flag
   assign irq_n = !((tx_clock_loss_irq_flag && !tx_clock_loss_irq_mask) // [RQ8]
                 || (dac_overflow_irq_flag && !dac_overflow_irq_mask)); // [RQ21]

   // RZ clock recovery: marks resync, a zero is inferred each idle bit
   assign rz_mark = is_rz && (pins[0] | pins[2]) && !(d_r[0] ^ tx_data_polarity_sel
                  | d_r[2] ^ tx_data_polarity_sel);                   // [RQ5]
   assign rz_zero = is_rz && !rz_mark && (rec_cnt_r == RW'(UI_CYCLES + HALF - 1));
   always_ff @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
         rec_cnt_r <= '0;
      end else if (!is_rz || rz_mark) begin
         rec_cnt_r <= '0;                                             // [RQ9]
      end else if (rz_zero) begin
         rec_cnt_r <= RW'(HALF - 1);
      end else begin
         rec_cnt_r <= rec_cnt_r + 1'b1;
      end
   end

   // Line encoder next state: AMI with optional zero substitution
   always_comb begin
      new_sym = pins[0] ? (pol_r ? LTX_SYM_NEG : LTX_SYM_POS) : LTX_SYM_ZERO;
      enc_nxt = {sym_r[6:0], new_sym};
      pol_nxt = pins[0] ? !pol_r : pol_r;
      odd_nxt = pins[0] ? !odd_r : odd_r;
      if (!pins[0] && tx_line_code_sel && !e1_mode && sym_r[6:0] == '0) begin
         enc_nxt[4] = pol_r ? LTX_SYM_POS : LTX_SYM_NEG;               // [RQ11]
         enc_nxt[3] = pol_r ? LTX_SYM_NEG : LTX_SYM_POS;
         enc_nxt[1] = pol_r ? LTX_SYM_NEG : LTX_SYM_POS;
         enc_nxt[0] = pol_r ? LTX_SYM_POS : LTX_SYM_NEG;
      end else if (!pins[0] && tx_line_code_sel && e1_mode && sym_r[2:0] == '0) begin
         odd_nxt = 1'b0;                                              // [RQ11]
         if (odd_r) begin
            enc_nxt[0] = pol_r ? LTX_SYM_POS : LTX_SYM_NEG;
         end else begin
            enc_nxt[3] = pol_r ? LTX_SYM_NEG : LTX_SYM_POS;
            enc_nxt[0] = pol_r ? LTX_SYM_NEG : LTX_SYM_POS;
            pol_nxt    = !pol_r;
         end
      end
   end

   // Encoder pipeline, eight bits deep, runs only in single rail
   always_ff @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
         sym_r <= '0;
         pol_r <= 1'b0;
         odd_r <= 1'b0;
      end else if (samp_stb && tx_format_select == LTX_FMT_SNRZ) begin
         sym_r <= enc_nxt;                                            // [RQ2] [RQ10]
         pol_r <= pol_nxt;
         odd_r <= odd_nxt;
      end
   end

   // Symbol source per format
   always_comb begin
      sym_stb = samp_stb;
      sym_val = {pins[0], pins[1]};                                   // [RQ4]
      if (is_rz) begin
         sym_stb = rz_mark || rz_zero;
         sym_val = rz_mark ? {pins[0], pins[2]} : LTX_SYM_ZERO;       // [RQ5] [RQ6]
      end else if (tx_format_select == LTX_FMT_SNRZ) begin
         sym_val = sym_r[7];                                          // [RQ10]
      end
   end

   // Shared status pin, refreshed per sampled bit
   always_ff @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
         status_r        <= 1'b0;
         tx_symbol       <= LTX_SYM_ZERO;
         tx_symbol_valid <= 1'b0;
      end else begin
         tx_symbol_valid <= sym_stb;
         if (sym_stb) begin
            tx_symbol <= sym_val;
            status_r  <= (is_rz || int'(status_sel) <= LTX_ST_NRZ_MAX) // [RQ3] [RQ5]
                       && tx_indications[status_sel];
         end
      end
   end
   assign link.b_dev    = status_r;
   assign link.b_dev_oe = (tx_format_select != LTX_FMT_DNRZ);         // [RQ6]

   // Amplitude scale register
   always_ff @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
         amplitude_scale <= LTX_SCALE_RST;                            // [RQ14]
      end else if (scale_we) begin
         amplitude_scale <= scale_wdata;
      end
   end

   // Waveform memory access through control and data registers
   assign acc_addr = wave_ctrl_wdata[4:0];
   assign acc_go   = wave_ctrl_we && wave_ctrl_wdata[LTX_WAC_DONE];
   assign acc_ok   = acc_go && int'(acc_addr) < LTX_NSAMP;            // [RQ17]
   always_ff @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
         wave_access_control_reg <= 7'h00;
         wave_sample_data_reg    <= 7'h00;
      end else begin
         if (wave_ctrl_we) begin
            wave_access_control_reg <= wave_ctrl_wdata;
         end else begin
            wave_access_control_reg[LTX_WAC_DONE] <= 1'b0;            // [RQ22]
         end
         if (acc_ok && wave_ctrl_wdata[LTX_WAC_RW]) begin
            wave_sample_data_reg <= mem_r[acc_addr];                  // [RQ20]
         end else if (wave_data_we) begin
            wave_sample_data_reg <= wave_data_wdata;                  // [RQ19]
         end
      end
   end
   always_ff @(posedge clk_sys) begin
      if (acc_ok && !wave_ctrl_wdata[LTX_WAC_RW]) begin
         mem_r[acc_addr] <= wave_sample_data_reg;                     // [RQ19]
      end
   end

   // Sample lookup: user memory, E1 templates, or the T1/J1 template
   function automatic ltx_samp_t samp_at(input logic [4:0] ph);
      if (pulse_template_sel[LTX_TMPL_USR]) begin
         return mem_r[ph];                                            // [RQ16]
      end else if (pulse_template_sel == LTX_TMPL_E1C) begin
         return LTX_ROM_E1C[ph];                                      // [RQ13]
      end else if (pulse_template_sel == LTX_TMPL_E1T) begin
         return LTX_ROM_E1T[ph];
      end
      return LTX_ROM_T1[ph];                                          // [RQ12]
   endfunction

   // Signed-magnitude sample to scaled signed amplitude
   function automatic int amp_of(input logic [4:0] ph, input logic neg);
      int f;
      int a;
      ltx_samp_t s;
      s = samp_at(ph);
      f = e1_mode ? LTX_PCT_BASE + (int'(amplitude_scale) - int'(LTX_SCALE_E1)) * LTX_PCT_E1
                  : LTX_PCT_BASE + (int'(amplitude_scale) - int'(LTX_SCALE_RST)) * LTX_PCT_T1;
      f = (f < 0) ? 0 : f;                                            // [RQ14] [RQ15]
      a = int'(s[5:0]) * f / LTX_PCT_BASE;                            // [RQ18]
      if (int'(ph) >= LTX_NSAMP) begin
         a = 0;
      end
      return (s[LTX_SGN_BIT] ^ neg) ? -a : a;
   endfunction

   // Current pulse and overlapping tail of the previous one
   always_ff @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
         cur_ph_r  <= 5'(LTX_NSAMP);
         prv_ph_r  <= 5'(LTX_NSAMP);
         cur_neg_r <= 1'b0;
         prv_neg_r <= 1'b0;
      end else if (sym_stb) begin
         prv_ph_r  <= (cur_ph_r == 5'(LTX_NSAMP)) ? cur_ph_r : cur_ph_r + 1'b1;
         prv_neg_r <= cur_neg_r;
         cur_ph_r  <= (sym_val == LTX_SYM_POS || sym_val == LTX_SYM_NEG) ? 5'h00
                    : 5'(LTX_NSAMP);
         cur_neg_r <= (sym_val == LTX_SYM_NEG);
      end else begin
         if (cur_ph_r != 5'(LTX_NSAMP)) begin
            cur_ph_r <= cur_ph_r + 1'b1;
         end
         if (prv_ph_r != 5'(LTX_NSAMP)) begin
            prv_ph_r <= prv_ph_r + 1'b1;
         end
      end
   end

   // DAC level: sum of both pulses, clamped at full scale
   always_comb sum_c = amp_of(cur_ph_r, cur_neg_r) + amp_of(prv_ph_r, prv_neg_r);
   always_ff @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
         tx_dac_level <= 8'h00;
      end else if (sum_c > LTX_AMP_MAX) begin
         tx_dac_level <= 8'(LTX_AMP_MAX);
      end else if (sum_c < -LTX_AMP_MAX) begin
         tx_dac_level <= 8'(-LTX_AMP_MAX);
      end else begin
         tx_dac_level <= 8'(sum_c);
      end
   end
endmodule

// ### ltx_chk.sv
// Link pin checks for the framer and device ends
`timescale 1ns/1ns
module ltx_chk import ltx_pkg::*; (
   // Clock and reset
   input wire logic       clk_sys,
   input wire logic       rst_b,
   // Formats and polarity
   input wire logic [1:0] fmt_h,
   input wire logic [1:0] fmt_d,
   input wire logic       pol,
   // Link pins
   input wire logic       line_a,
   input wire logic       line_c,
   input wire logic       b_host_oe,
   input wire logic       b_dev_oe
);
   default clocking @(posedge clk_sys); endclocking
   default disable iff (!rst_b);
   logic nrz;
   // Framer clock only runs in the NRZ formats
   assign nrz = fmt_h != LTX_FMT_DRZ;
   // Pin direction per format
   chk_dev_oe_fmt: assert property (b_dev_oe == (fmt_d != LTX_FMT_DNRZ))
      else $error("device enable wrong");
   chk_host_oe_fmt: assert property (b_host_oe == (fmt_h == LTX_FMT_DNRZ))
      else $error("framer enable wrong");
   chk_no_contention: assert property (fmt_h == fmt_d |-> !(b_host_oe && b_dev_oe))
      else $error("shared pin contention");
   // Line clock shape, six high and six low
   chk_clk_high_time: assert property (nrz && $rose(line_c) |=> line_c [*5] ##1 !line_c)
      else $error("clock high time");
   chk_clk_low_time: assert property (nrz && $fell(line_c) |=> !line_c [*5] ##1 line_c)
      else $error("clock low time");
   chk_clk_period: assert property (nrz && $rose(line_c) |-> ##12 $rose(line_c))
      else $error("clock period");
   // Rails never mark together in RZ, pins idle after reset
   chk_rz_rails_apart: assert property (!nrz |-> !((line_a ^ pol) && (line_c ^ pol)))
      else $error("both rails marked");
   chk_reset_idle: assert property ($rose(rst_b) |->
      !(line_a ^ pol) && !(line_c ^ (pol && !nrz)))
      else $error("pins not idle");
   // Main traffic seen
   cover property (nrz && $rose(line_c));
   cover property (!nrz && $rose(line_a ^ pol));
   cover property (b_host_oe);
endmodule

// ### lineunit_transmit_path_test.sv
// Self-checking bench joining framer and device ends over the link
`timescale 1ns/1ns
module lineunit_transmit_path_test import ltx_pkg::*;;
   logic       clk_sys, rst_b, in_valid, in_ready, seen, pol, esel, csel, e1, sc_we, wc_we;
   logic       wd_we, lsel, lmask, dmask, cl_st, cl_fl, dac_fl, irq_n, sym_v;
   logic [1:0] fmt_h, fmt_d, in_data, iclr, sym, s1, s2;
   logic [3:0] tmpl;
   logic [2:0] ssel;
   logic [7:0] ind, dac;
   logic [5:0] scale;
   logic [6:0] wd, wctl, wdat;
   int         mismatches, checked;
   ltx_link_if link();
   ltx_framer ltx_framer_i(.clk_sys, .rst_b, .link(link), .fmt(fmt_h), .edge_sel(esel),
      .polarity_sel(pol), .in_valid, .in_ready, .in_data, .status_seen(seen));
   ltx_lineunit ltx_lineunit_i(.clk_sys, .rst_b, .link(link), .tx_format_select(fmt_d),
      .tx_data_polarity_sel(pol), .tx_clock_edge_sel(esel), .tx_line_code_sel(csel),
      .e1_mode(e1), .pulse_template_sel(tmpl), .status_sel(ssel), .tx_indications(ind),
      .scale_we(sc_we), .scale_wdata(wd[5:0]), .amplitude_scale(scale), .wave_ctrl_we(wc_we),
      .wave_ctrl_wdata(wd), .wave_data_we(wd_we), .wave_data_wdata(wd),
      .wave_access_control_reg(wctl), .wave_sample_data_reg(wdat),
      .tx_clock_loss_edge_sel(lsel), .tx_clock_loss_irq_mask(lmask),
      .dac_overflow_irq_mask(dmask), .irq_clear(iclr), .tx_clock_loss_status(cl_st),
      .tx_clock_loss_irq_flag(cl_fl), .dac_overflow_irq_flag(dac_fl), .irq_n,
      .tx_symbol(sym), .tx_symbol_valid(sym_v), .tx_dac_level(dac));
   ltx_chk ltx_chk_i(.clk_sys, .rst_b, .fmt_h, .fmt_d, .pol, .line_a(link.line_a),
      .line_c(link.line_c), .b_host_oe(link.b_host_oe), .b_dev_oe(link.b_dev_oe));
   // Clock
   initial begin
      clk_sys = 1'b0;
      forever #25 clk_sys = ~clk_sys;
   end
   task automatic cmp(input logic [7:0] got, input logic [7:0] exp);
      checked++;
      if (got !== exp) begin
         mismatches++;
         $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic conclude();
      $display("checked=%0d mismatches=%0d", checked, mismatches);
      if (mismatches == 0 && checked > 0) $display("*** PASS ***");
      else $display("*** FAIL ***");
      $finish;
   endtask
   // Reset with both ends' formats set while held
   task automatic restart(input logic [1:0] fh, input logic [1:0] fd, input logic p);
      rst_b = 1'b0;
      in_valid = 1'b0;
      {fmt_h, fmt_d, pol} = {fh, fd, p};
      repeat (5) @(negedge clk_sys);
      rst_b = 1'b1;
   endtask
   // Register write: 0 scale, 1 access control, 2 sample data
   task automatic wr(input int k, input logic [6:0] d);
      @(negedge clk_sys);
      {sc_we, wc_we, wd_we} = {k == 0, k == 1, k == 2};
      wd = d;
      @(negedge clk_sys);
      {sc_we, wc_we, wd_we} = 3'h0;
   endtask
   // Next marked symbol on the line side
   task automatic next_mark(output logic [1:0] s);
      int n = 0;
      @(negedge clk_sys);
      while (!(sym_v === 1'b1 && sym !== 2'h0) && n < 600) begin
         @(negedge clk_sys);
         n++;
      end
      s = sym;
   endtask
   // Watchdog
   initial begin
      #(40000 * 50);
      mismatches++;
      conclude();
   end
   initial begin
      {sc_we, wc_we, wd_we, esel, e1, csel, lsel, lmask, dmask} = '0;
      {ssel, ind, iclr, in_data, wd} = '0;
      tmpl = 4'h2;
      restart(LTX_FMT_DNRZ, LTX_FMT_DNRZ, 1'b0);
      cmp(scale, 8'h36);
      cmp(irq_n, 8'h1);
      wr(0, 7'h21);
      cmp(scale, 8'h21);
      wr(0, 7'h3F);
      for (int i = 0; i < 21; i++) begin
         wr(2, 7'h20 + 7'(i));
         wr(1, {2'h2, 5'(i)});
      end
      for (int i = 0; i < 21; i++) begin
         wr(1, {2'h3, 5'(i)});
         cmp(wctl[6], 8'h1);
         @(negedge clk_sys);
         cmp(wctl, {3'h1, 5'(i)});
         cmp(wdat, i < 20 ? 8'h20 + 8'(i) : 8'h33);
      end
      $display("test waveform memory done");
      {tmpl, csel, in_data, in_valid} = {4'h8, 1'b1, 2'h2, 1'b1};
      next_mark(s1);
      cmp(s1, LTX_SYM_POS);
      repeat (60) @(negedge clk_sys);
      cmp(dac_fl, 8'h1);
      cmp(irq_n, 8'h0);
      for (int n = 0; n < 12 && dac !== 8'h3F; n++) @(negedge clk_sys);
      cmp(dac, 8'h3F);
      dmask = 1'b1;
      @(negedge clk_sys);
      cmp(irq_n, 8'h1);
      $display("test dual nrz done");
      restart(LTX_FMT_SNRZ, LTX_FMT_SNRZ, 1'b0);
      {tmpl, csel, in_data, in_valid} = {4'h2, 1'b0, 2'h2, 1'b1};
      {ssel, ind} = {3'h1, 8'h22};
      next_mark(s1);
      next_mark(s2);
      cmp(s1[1] ^ s1[0], 8'h1);
      cmp(s2, {s1[0], s1[1]});
      cmp(seen, 8'h1);
      {csel, in_data, ssel} = {1'b1, 2'h0, 3'h5};
      repeat (400) @(negedge clk_sys);
      next_mark(s1);
      cmp(s1 inside {LTX_SYM_POS, LTX_SYM_NEG}, 8'h1);
      cmp(seen, 8'h0);
      $display("test single nrz done");
      restart(LTX_FMT_DRZ, LTX_FMT_DRZ, 1'b1);
      {e1, tmpl, in_data, in_valid} = {1'b1, 4'h0, 2'h1, 1'b1};
      next_mark(s1);
      cmp(s1, LTX_SYM_NEG);
      cmp(cl_st, 8'h0);
      repeat (3) @(negedge clk_sys);
      cmp(seen, 8'h1);
      $display("test dual rz done");
      restart(LTX_FMT_DRZ, LTX_FMT_SNRZ, 1'b0);
      {lsel, lmask} = 2'h2;
      repeat (800) @(negedge clk_sys);
      cmp(cl_st, 8'h0);
      for (int n = 0; n < 100 && cl_st !== 1'b1; n++) @(negedge clk_sys);
      cmp(cl_st, 8'h1);
      @(negedge clk_sys);
      cmp({cl_fl, irq_n}, 8'h2);
      iclr = 2'h1;
      @(negedge clk_sys);
      iclr = 2'h0;
      cmp(cl_fl, 8'h0);
      @(negedge ltx_framer_i.clk_r);
      @(negedge clk_sys);
      fmt_h = LTX_FMT_SNRZ;
      for (int n = 0; n < 40 && cl_st !== 1'b0; n++) @(negedge clk_sys);
      cmp(cl_st, 8'h0);
      @(negedge clk_sys);
      cmp(cl_fl, 8'h1);
      $display("test clock loss done");
      conclude();
   end
endmodule
